// ### hw/tws_map.svh
/*
  Register offsets, field positions, reset values and status codes of the
  two-wire slave. Assumes inclusion by the slave core alone.
*/
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_OFF_CTRL    8'h00
`define TWS_OFF_ADDR    8'h04
`define TWS_OFF_STAT    8'h08
`define TWS_OFF_DATA    8'h0c

`define TWS_CTRL_IFLAG  7
`define TWS_CTRL_ACK    6
`define TWS_CTRL_STA    5
`define TWS_CTRL_STO    4
`define TWS_CTRL_WCOL   3
`define TWS_CTRL_EN     2
`define TWS_CTRL_IE     0
`define TWS_ADDR_GCE    0

`define TWS_RST_ADDR    8'h00
`define TWS_RST_DATA    8'hff
`define TWS_GC_ADDR     7'h00

`define TWS_ST_SR_OWN   8'h60
`define TWS_ST_SR_ARB   8'h68
`define TWS_ST_GC_OWN   8'h70
`define TWS_ST_GC_ARB   8'h78
`define TWS_ST_SR_ACK   8'h80
`define TWS_ST_SR_NACK  8'h88
`define TWS_ST_GC_ACK   8'h90
`define TWS_ST_GC_NACK  8'h98
`define TWS_ST_STOP     8'ha0
`define TWS_ST_ST_OWN   8'ha8
`define TWS_ST_ST_ARB   8'hb0
`define TWS_ST_ST_ACK   8'hb8
`define TWS_ST_ST_NACK  8'hc0
`define TWS_ST_ST_LAST  8'hc8
`define TWS_ST_NONE     8'hf8

`endif

// ### hw/tws_pkg.sv
/*
  Types shared by the two-wire slave modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tws_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX_DATA, ST_RX_ACK, ST_TX_DATA, ST_TX_ACK, ST_DONE
  } tws_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_s;

  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic busFree;
  } tws_cond_s;
endpackage

// ### hw/tws_sync.sv
/*
  Two-flop synchroniser, one stage pair per bit.
  Assumes asynchronous inputs and a free running clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // Idle bus level is high, so reset to one
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          meta[i]    <= 1'b1;
          syncOut[i] <= 1'b1;
        end
        else
        begin
          meta[i]    <= asyncIn[i];
          syncOut[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### hw/tws_bus_cond.sv
/*
  Bus condition detector: SCL edges, START, STOP and bus-free level.
  Assumes already synchronised SCL and SDA.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_bus_cond (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire tws_pkg::tws_pins_s pins,
  output var  tws_pkg::tws_cond_s cond
);
  tws_pkg::tws_pins_s prev;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      prev <= '1;
      cond <= '{busFree: 1'b1, default: 1'b0};
    end
    else
    begin
      prev         <= pins;
      cond.sclRise <= !prev.scl && pins.scl;
      cond.sclFall <= prev.scl && !pins.scl;
      cond.start   <= prev.scl && pins.scl && prev.sda && !pins.sda;
      cond.stop    <= prev.scl && pins.scl && !prev.sda && pins.sda;
      if (prev.scl && pins.scl && !prev.sda && pins.sda)
        cond.busFree <= 1'b1;
      else if (prev.scl && pins.scl && prev.sda && !pins.sda)
        cond.busFree <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### hw/tws_slave.sv
/*
  Two-wire slave receiver/transmitter core with APB register access.
  Assumes an external bus master on SCL/SDA and an APB master on clk_sys.
*/
// The APB register port and the register addresses were chosen for this implementation.
`include "tws_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tws_slave #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sclOut,
  output var  logic              sclOe,
  output logic                   sdaOut,
  output var  logic              sdaOe,
  input  wire logic              sleepMode,
  input  wire logic              arbLost,
  output var  logic              wakeReq,
  output var  logic              startGo,
  output var  logic              irqLevel
);
  tws_pkg::tws_pins_s  pinsS;
  tws_pkg::tws_cond_s  cond;
  tws_pkg::tws_state_e state;

  // Local aliases of the state literals, since nothing is imported
  localparam tws_pkg::tws_state_e ST_IDLE     = tws_pkg::ST_IDLE;
  localparam tws_pkg::tws_state_e ST_ADDR     = tws_pkg::ST_ADDR;
  localparam tws_pkg::tws_state_e ST_ADDR_ACK = tws_pkg::ST_ADDR_ACK;
  localparam tws_pkg::tws_state_e ST_RX_DATA  = tws_pkg::ST_RX_DATA;
  localparam tws_pkg::tws_state_e ST_RX_ACK   = tws_pkg::ST_RX_ACK;
  localparam tws_pkg::tws_state_e ST_TX_DATA  = tws_pkg::ST_TX_DATA;
  localparam tws_pkg::tws_state_e ST_TX_ACK   = tws_pkg::ST_TX_ACK;
  localparam tws_pkg::tws_state_e ST_DONE     = tws_pkg::ST_DONE;

  logic       iflag, ackEn, staReq, stoReq, wcol, ifEn, irqEn;
  logic [7:0] osa, dataReg, status, shiftReg, evCode;
  logic [1:0] presc;
  logic [3:0] bitCnt;
  logic       isRead, isGc, rxAck, lastByte, masterAck, arbLatch;
  logic       evSet, evStore, startPend;
  logic       apbWr, apbAcc, mapped, flagClr, addrMatch;

  tws_sync #(.WIDTH(2)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .asyncIn ({sclIn, sdaIn}),
    .syncOut (pinsS)
  );

  tws_bus_cond u_cond (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pins    (pinsS),
    .cond    (cond)
  );

  // Zero-wait APB slave
  assign apbAcc  = psel && penable;
  assign apbWr   = apbAcc && pwrite;
  assign mapped  = paddr == ADDR_W'(`TWS_OFF_CTRL) || paddr == ADDR_W'(`TWS_OFF_ADDR)
                || paddr == ADDR_W'(`TWS_OFF_STAT) || paddr == ADDR_W'(`TWS_OFF_DATA);
  assign pready  = 1'b1;
  assign pslverr = apbAcc && !mapped;
  assign flagClr = apbWr && paddr == ADDR_W'(`TWS_OFF_CTRL) && pwdata[`TWS_CTRL_IFLAG] && iflag;
  assign sclOut  = 1'b0;
  assign sdaOut  = 1'b0;

  // Own address or enabled general call; ack_enable gates the answer
  assign addrMatch = ifEn && ackEn
                  && (shiftReg[7:1] == osa[7:1]
                  || (shiftReg[7:1] == `TWS_GC_ADDR && osa[`TWS_ADDR_GCE]));

  // Read data registered in the setup phase
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      prdata <= '0;
    else if (psel && !penable)
    begin
      case (paddr)
        ADDR_W'(`TWS_OFF_CTRL): prdata <= {24'h0, iflag, ackEn, staReq, stoReq, wcol, ifEn, 1'b0, irqEn};
        ADDR_W'(`TWS_OFF_ADDR): prdata <= {24'h0, osa};
        ADDR_W'(`TWS_OFF_STAT): prdata <= {24'h0, status[7:3], 1'b0, presc};
        ADDR_W'(`TWS_OFF_DATA): prdata <= {24'h0, dataReg};
        default:                prdata <= '0;
      endcase
    end
  end

  // Control bits written by software
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ackEn  <= 1'b0;
      staReq <= 1'b0;
      stoReq <= 1'b0;
      ifEn   <= 1'b0;
      irqEn  <= 1'b0;
      osa    <= `TWS_RST_ADDR;
      presc  <= 2'h0;
    end
    else if (apbWr)
    begin
      if (paddr == ADDR_W'(`TWS_OFF_CTRL))
      begin
        ackEn  <= pwdata[`TWS_CTRL_ACK];
        staReq <= pwdata[`TWS_CTRL_STA];
        stoReq <= pwdata[`TWS_CTRL_STO];
        ifEn   <= pwdata[`TWS_CTRL_EN];
        irqEn  <= pwdata[`TWS_CTRL_IE];
      end
      if (paddr == ADDR_W'(`TWS_OFF_ADDR))
        osa <= pwdata[7:0];
      if (paddr == ADDR_W'(`TWS_OFF_STAT))
        presc <= pwdata[1:0];
    end
  end

  // Flag and status: a hardware set wins over a software clear
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      iflag  <= 1'b0;
      status <= `TWS_ST_NONE;
    end
    else if (evSet)
    begin
      iflag  <= 1'b1;
      status <= evCode;
    end
    else if (flagClr)
    begin
      iflag  <= 1'b0;
      status <= `TWS_ST_NONE;
    end
  end

  // Data register; a write while the flag is clear collides
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dataReg <= `TWS_RST_DATA;
      wcol    <= 1'b0;
    end
    else
    begin
      if (evStore)
        dataReg <= shiftReg;
      else if (apbWr && paddr == ADDR_W'(`TWS_OFF_DATA))
      begin
        if (iflag)
          dataReg <= pwdata[7:0];
        else
          wcol <= 1'b1;
      end
      if (apbWr && paddr == ADDR_W'(`TWS_OFF_DATA) && iflag)
        wcol <= 1'b0;
    end
  end

  // Leaving an addressed state with start_request set arms a START
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      startPend <= 1'b0;
      startGo   <= 1'b0;
    end
    else
    begin
      startGo <= startPend && cond.busFree && ifEn;
      if (startPend && cond.busFree && ifEn)
        startPend <= 1'b0;
      // Request bit written together with the clear counts
      else if (flagClr && pwdata[`TWS_CTRL_STA] && (status == `TWS_ST_SR_NACK || status == `TWS_ST_GC_NACK
               || status == `TWS_ST_STOP || status == `TWS_ST_ST_NACK || status == `TWS_ST_ST_LAST))
        startPend <= 1'b1;
    end
  end

  // Lost arbitration is remembered until the next address acknowledge ends
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      arbLatch <= 1'b0;
    else if (arbLost)
      arbLatch <= 1'b1;
    else if (state == ST_ADDR_ACK && cond.sclFall)
      arbLatch <= 1'b0;
  end

  // Byte engine: bits counted on SCL rise, phases advance on SCL fall
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      isRead    <= 1'b0;
      isGc      <= 1'b0;
      rxAck     <= 1'b0;
      lastByte  <= 1'b0;
      masterAck <= 1'b0;
      evSet     <= 1'b0;
      evStore   <= 1'b0;
      evCode    <= `TWS_ST_NONE;
      wakeReq   <= 1'b0;
    end
    else
    begin
      evSet   <= 1'b0;
      evStore <= 1'b0;
      wakeReq <= 1'b0;
      if (!ifEn)
        state <= ST_IDLE;
      else if (cond.start || cond.stop)
      begin
        // Bus is still monitored whatever ack_enable says
        if (state == ST_RX_DATA || state == ST_RX_ACK)
        begin
          evSet  <= 1'b1;
          evCode <= `TWS_ST_STOP;
        end
        state  <= cond.start ? ST_ADDR : ST_IDLE;
        bitCnt <= 4'h0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            bitCnt <= 4'h0;
          ST_ADDR:
            if (cond.sclRise)
            begin
              shiftReg <= {shiftReg[6:0], pinsS.sda};
              bitCnt   <= bitCnt + 4'h1;
            end
            else if (cond.sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              isRead <= shiftReg[0];
              isGc   <= shiftReg[7:1] == `TWS_GC_ADDR;
              state  <= addrMatch ? ST_ADDR_ACK : ST_IDLE;
              wakeReq <= addrMatch && sleepMode;
            end
          ST_ADDR_ACK:
            if (cond.sclFall)
            begin
              evSet <= 1'b1;
              if (isRead)
              begin
                evCode <= arbLatch ? `TWS_ST_ST_ARB : `TWS_ST_ST_OWN;
                state  <= ST_TX_DATA;
              end
              else
              begin
                evCode <= isGc ? (arbLatch ? `TWS_ST_GC_ARB : `TWS_ST_GC_OWN)
                               : (arbLatch ? `TWS_ST_SR_ARB : `TWS_ST_SR_OWN);
                state  <= ST_RX_DATA;
              end
            end
          ST_RX_DATA:
            if (cond.sclRise)
            begin
              shiftReg <= {shiftReg[6:0], pinsS.sda};
              bitCnt   <= bitCnt + 4'h1;
            end
            else if (cond.sclFall && bitCnt == 4'h8)
            begin
              bitCnt <= 4'h0;
              rxAck  <= ackEn;
              state  <= ST_RX_ACK;
            end
          ST_RX_ACK:
            if (cond.sclFall)
            begin
              evSet   <= 1'b1;
              evStore <= !sleepMode;
              if (isGc)
                evCode <= rxAck ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
              else
                evCode <= rxAck ? `TWS_ST_SR_ACK : `TWS_ST_SR_NACK;
              state  <= rxAck ? ST_RX_DATA : ST_DONE;
            end
          ST_TX_DATA:
            if (flagClr)
            begin
              // Byte is taken when software releases the bus
              shiftReg <= dataReg;
              // Ack bit written with the clear decides the last byte
              lastByte <= !pwdata[`TWS_CTRL_ACK];
              bitCnt   <= 4'h0;
            end
            else if (cond.sclRise)
              bitCnt <= bitCnt + 4'h1;
            else if (cond.sclFall && !iflag)
            begin
              if (bitCnt == 4'h8)
                state <= ST_TX_ACK;
              else
                shiftReg <= {shiftReg[6:0], 1'b1};
            end
          ST_TX_ACK:
            if (cond.sclRise)
              masterAck <= !pinsS.sda;
            else if (cond.sclFall)
            begin
              evSet <= 1'b1;
              if (!masterAck)
                evCode <= `TWS_ST_ST_NACK;
              else
                evCode <= lastByte ? `TWS_ST_ST_LAST : `TWS_ST_ST_ACK;
              state <= (masterAck && !lastByte) ? ST_TX_DATA : ST_DONE;
            end
          ST_DONE:
            // Not addressed once the flag is cleared; further reads see ones
            if (flagClr)
              state <= ST_IDLE;
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain drives; SCL held low while software owes an answer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end
    else
    begin
      sclOe <= iflag && (state == ST_RX_DATA || state == ST_TX_DATA || state == ST_DONE);
      case (state)
        ST_ADDR_ACK: sdaOe <= 1'b1;
        ST_RX_ACK:   sdaOe <= rxAck;
        ST_TX_DATA:  sdaOe <= !iflag && !shiftReg[7];
        default:     sdaOe <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      irqLevel <= 1'b0;
    else
      irqLevel <= iflag && irqEn;
  end

  AST_GC_ACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_RX_ACK && cond.sclFall && isGc && rxAck && ifEn && !cond.start && !cond.stop
    |=> evSet && evCode == `TWS_ST_GC_ACK ##1 iflag && status == `TWS_ST_GC_ACK)
    else $error("general call ack status wrong");
  AST_GC_NACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_RX_ACK && cond.sclFall && isGc && !rxAck && ifEn && !cond.start && !cond.stop
    |=> evCode == `TWS_ST_GC_NACK && state == ST_DONE)
    else $error("general call nack handling wrong");
  AST_STOP_ADDR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ifEn && cond.stop && state == ST_RX_DATA |=> evSet && evCode == `TWS_ST_STOP && state == ST_IDLE)
    else $error("stop while addressed not reported");
  AST_START_GO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    startPend && cond.busFree && ifEn |=> startGo && !startPend)
    else $error("pending start not issued");
  AST_NO_MATCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_ADDR && cond.sclFall && bitCnt == 4'h8 && !cond.start && !cond.stop && ifEn
    && shiftReg[7:1] != osa[7:1] && !(shiftReg[7:1] == 7'h00 && osa[0]) |=> state == ST_IDLE)
    else $error("foreign address answered");
  AST_ACK_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_ADDR && !ackEn |=> !sdaOe [*2])
    else $error("address acked with ack disabled");
  AST_READ_OWN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_ADDR_ACK && cond.sclFall && isRead && !arbLatch && ifEn && !cond.start && !cond.stop
    |=> evCode == `TWS_ST_ST_OWN && state == ST_TX_DATA ##1 iflag)
    else $error("own read address status wrong");
  AST_LAST_ACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_TX_ACK && cond.sclFall && masterAck && lastByte && ifEn && !cond.start && !cond.stop
    |=> evCode == `TWS_ST_ST_LAST && state == ST_DONE)
    else $error("last byte ack status wrong");
  AST_TX_NACK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_TX_ACK && cond.sclFall && !masterAck && ifEn && !cond.start && !cond.stop
    |=> evCode == `TWS_ST_ST_NACK ##1 status == `TWS_ST_ST_NACK)
    else $error("transmit nack status wrong");
  AST_STRETCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    iflag && state == ST_TX_DATA && !evSet && !flagClr |=> sclOe)
    else $error("scl not stretched");
  AST_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ST_IDLE |=> !sdaOe)
    else $error("sda driven when not addressed");

  COV_READ: cover property (@(posedge clk_sys) evSet && evCode == `TWS_ST_ST_OWN);
  COV_LAST: cover property (@(posedge clk_sys) evSet && evCode == `TWS_ST_ST_LAST);
  COV_GC:   cover property (@(posedge clk_sys) evSet && evCode == `TWS_ST_GC_ACK);
  COV_WAKE: cover property (@(posedge clk_sys) wakeReq);
endmodule
`default_nettype wire

// ### verif/tws_bus_master.sv
/*
  Bus master model for the two-wire slave: START, STOP and byte transfers.
  Assumes open-drain lines that the bench resolves with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
module tws_bus_master (
  input  wire logic clk_sys,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output var  logic sclDrv,
  output var  logic sdaDrv,
  output var  logic hung
);
  initial
  begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
    hung   = 1'b0;
  end

  // Quarter of the 80 ns bus period
  task automatic quarter();
    repeat (4) @(posedge clk_sys);
  endtask

  // Also serves as repeated START from a low SCL
  task automatic start();
    quarter();
    sdaDrv <= 1'b1;
    quarter();
    sclDrv <= 1'b1;
    quarter();
    sdaDrv <= 1'b0;
    quarter();
    sclDrv <= 1'b0;
  endtask

  task automatic stop();
    quarter();
    sdaDrv <= 1'b0;
    quarter();
    sclDrv <= 1'b1;
    quarter();
    sdaDrv <= 1'b1;
    quarter();
  endtask

  task automatic bitx(input logic d, output logic b);
    int n;
    quarter();
    sdaDrv <= d;
    quarter();
    sclDrv <= 1'b1;
    // Slave may stretch; bounded so a stuck SCL shows up
    for (n = 0; n < 5000 && sclLine !== 1'b1; n++)
      @(posedge clk_sys);
    if (n == 5000)
      hung <= 1'b1;
    quarter();
    quarter();
    b = sdaLine;
    sclDrv <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackSeen);
    for (int i = 7; i >= 0; i--)
      bitx(tx[i], rx[i]);
    bitx(ackIn, ackSeen);
  endtask
endmodule
`default_nettype wire

// ### verif/two_wire_slave_tx_rx_test.sv
/*
  Self-checking bench of the two-wire slave: APB software plus a bus master model.
  Assumes the hand-over timing of the design and a 200 MHz clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_tx_rx_test;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleepMode = 1'b0, arbLost = 1'b0;
  logic [7:0]  paddr = 8'h00, rb, d;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, wakeReq, startGo, irqLevel;
  logic        sclDrv, sdaDrv, hung, rerr, ak, fin;
  logic [6:0]  own;
  int          seed, checks, n_mismatch, nGo, nWake, k, j, n;

  wire logic sclLine = sclDrv & ~sclOe;
  wire logic sdaLine = sdaDrv & ~sdaOe;

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    nGo <= nGo + int'(startGo === 1'b1);
    nWake <= nWake + int'(wakeReq === 1'b1);
  end

  tws_slave dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
    .sdaIn(sdaLine), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .sleepMode(sleepMode),
    .arbLost(arbLost), .wakeReq(wakeReq), .startGo(startGo), .irqLevel(irqLevel));

  tws_bus_master m (.clk_sys(clk_sys), .sclLine(sclLine), .sdaLine(sdaLine), .sclDrv(sclDrv),
    .sdaDrv(sdaDrv), .hung(hung));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk_sys);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 50)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  function automatic logic [31:0] endCode(input logic nack);
    return nack ? 32'hc0 : 32'hc8;
  endfunction

  // Status compared with prescaler bits masked off
  task automatic stat(input logic [31:0] code);
    repeat (8) @(posedge clk_sys);
    apb(1'b0, 8'h08, 32'h0);
    chk("status", rdat & 32'hf8, code);
    chk("irq", 32'(irqLevel), 32'h1);
  endtask

  task automatic adr(input logic [7:0] b, input logic expSda);
    m.start();
    m.xfer(b, 1'b1, rb, ak);
    chk("address ack", 32'(ak), 32'(expSda));
  endtask

  initial
  begin
    seed = 76;
    own = 7'($random(seed)) | 7'h08;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk("reset value", rdat, (k == 2) ? 32'hf8 : (k == 3) ? 32'hff : 32'h0);
    end
    apb(1'b1, 8'h10, 32'hff);
    chk("unmapped error", 32'(rerr), 32'h1);
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk("prescaler", rdat, 32'hfb);
    apb(1'b1, 8'h04, 32'({own, 1'b0}));
    apb(1'b1, 8'h00, 32'h45);
    for (k = 0; k < 2; k++)
    begin
      m.start();
      @(posedge clk_sys);
      arbLost <= (k == 1);
      @(posedge clk_sys);
      arbLost <= 1'b0;
      m.xfer({own, 1'b1}, 1'b1, rb, ak);
      chk("read address ack", 32'(ak), 32'h0);
      stat(k ? 32'hb0 : 32'ha8);
      chk("stretch", 32'(sclOe), 32'h1);
      for (j = 0; j < 2 - k; j++)
      begin
        fin = (j == 1 - k);
        d = 8'($random(seed));
        apb(1'b1, 8'h0c, 32'(d));
        apb(1'b1, 8'h00, fin ? 32'h85 : 32'hc5);
        m.xfer(8'hff, fin & k[0], rb, ak);
        chk("tx data", 32'(rb), 32'(d));
        stat(fin ? endCode(k[0]) : 32'hb8);
      end
      apb(1'b1, 8'h00, 32'hc5);
      if (k == 0)
      begin
        m.xfer(8'hff, 1'b1, rb, ak);
        chk("released data", 32'(rb), 32'hff);
      end
      m.stop();
    end
    apb(1'b1, 8'h00, 32'h05);
    adr({own, 1'b0}, 1'b1);
    m.stop();
    apb(1'b1, 8'h00, 32'h45);
    adr({own ^ 7'h01, 1'b0}, 1'b1);
    m.stop();
    adr({own, 1'b0}, 1'b0);
    stat(32'h60);
    apb(1'b1, 8'h00, 32'hc5);
    m.stop();
    stat(32'ha0);
    apb(1'b1, 8'h00, 32'hc5);
    apb(1'b1, 8'h04, 32'({own, 1'b1}));
    adr(8'h00, 1'b0);
    stat(32'h70);
    for (k = 0; k < 2; k++)
    begin
      apb(1'b1, 8'h00, k ? 32'h85 : 32'hc5);
      m.xfer(8'($random(seed)), 1'b1, rb, ak);
      chk("rx ack", 32'(ak), 32'(k));
      stat(k ? 32'h98 : 32'h90);
    end
    apb(1'b1, 8'h00, 32'he5);
    repeat (20) @(posedge clk_sys);
    chk("start while busy", nGo, 0);
    m.stop();
    for (n = 0; n < 500 && nGo == 0; n++)
      @(posedge clk_sys);
    chk("start when free", nGo, 1);
    apb(1'b1, 8'h00, 32'h45);
    apb(1'b1, 8'h04, 32'({own, 1'b0}));
    adr(8'h00, 1'b1);
    m.stop();
    sleepMode <= 1'b1;
    adr({own, 1'b1}, 1'b0);
    stat(32'ha8);
    chk("wake", nWake, 1);
    chk("sleep stretch", 32'(sclOe), 32'h1);
    sleepMode <= 1'b0;
    apb(1'b1, 8'h00, 32'h85);
    m.xfer(8'hff, 1'b1, rb, ak);
    stat(32'hc0);
    apb(1'b1, 8'h00, 32'hc5);
    repeat (8) @(posedge clk_sys);
    chk("sda released", 32'(sdaOe), 32'h0);
    m.stop();
    chk("master stall", 32'(hung), 32'h0);
    chk("open drain values", 32'({sclOut, sdaOut}), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
